// ===== testbench/scr_board_model.sv
/*
  Board side of the chain: straps, switches and status flags.
  Assumes static levels for the length of a run.
*/
`timescale 1ns/1ns
`default_nettype none
module scr_board_model #(
  parameter logic [7:0] ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] REV = 8'h13,
  parameter logic [3:0] SW = 4'ha,
  parameter logic [1:0] RISER = 2'h1,
  parameter logic [2:0] FLAGS = 3'h6
) (
  // Status pins toward the reader
  output logic [7:0] id_o,
  output logic [7:0] rev_o,
  output logic [3:0] sw_o,
  output logic [1:0] riser_o,
  output logic fan_o,
  output logic temp_o,
  output logic cpu1_o,
  output logic cpu2_o
);
  // Static board levels
  assign id_o = ID;
  assign rev_o = REV;
  assign sw_o = SW;
  assign riser_o = RISER;
  assign fan_o = FLAGS[2];
  assign temp_o = 1'b0;
  assign cpu2_o = FLAGS[1];
  assign cpu1_o = FLAGS[0];
endmodule : scr_board_model
`default_nettype wire

// ===== testbench/scr_reader_monitor.sv
/*
  Port checker for the board status chain reader.
  Assumes it is bound into every scr_reader instance.
*/
`timescale 1ns/1ns
`default_nettype none
module scr_reader_monitor
  import scr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Port access
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  // Events and outputs
  input wire logic ecc_correctable_i,
  input wire logic fan1_error_i,
  input wire logic fan2_error_i,
  input wire logic temp1_caution_i,
  input wire logic temp2_caution_i,
  input wire logic irq13_o,
  input wire logic hot_spare_boot_advance_o,
  input wire logic fifo_overflow_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] ctl_q, ctl_d;
  logic [5:0] age_q, age_d;
  logic ev_on;
  // Shadow of the control port and age of the last shift trigger
  always_comb begin
    ctl_d = ctl_q;
    age_d = (age_q == 6'h3f) ? age_q : age_q + 6'h01;
    if (io_wr_i && io_addr_i == SCAN_CONTROL_PORT_ADDR) begin
      ctl_d = io_wdata_i;
      if (io_wdata_i[7] && !ctl_q[7]) age_d = 6'h00;
    end
    if (!resetn_i) begin
      ctl_d = CONTROL_RESET;
      age_d = 6'h3f;
    end
  end
  always_ff @(posedge clk_i) begin
    ctl_q <= ctl_d;
    age_q <= age_d;
  end
  // Any event source that its enable lets through
  assign ev_on = (ecc_correctable_i && ctl_q[4]) ||
    (fan2_error_i && ctl_q[3]) || (fan1_error_i && ctl_q[2]) ||
    (temp2_caution_i && !ctl_q[1]) || (temp1_caution_i && !ctl_q[0]);
  sequence s_ctl_write;
    io_wr_i && io_addr_i == SCAN_CONTROL_PORT_ADDR;
  endsequence
  sequence s_ctl_look;
    !io_wr_i && io_addr_i == SCAN_CONTROL_PORT_ADDR;
  endsequence
  property p_ctl_rb;
    s_ctl_write ##1 s_ctl_look |-> io_rdata_o == $past(io_wdata_i);
  endproperty
  a_ctl_rb: assert property (p_ctl_rb)
    else $error("control port readback wrong");
  property p_unmapped;
    io_addr_i != SCAN_CONTROL_PORT_ADDR &&
      io_addr_i != SCAN_DATA_PORT_ADDR |-> io_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_irq_on;
    ev_on [*5] |-> irq13_o;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled event without interrupt");
  property p_irq_off;
    !ev_on [*5] |-> !irq13_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt without enabled event");
  property p_spare_off;
    !ctl_q[5] [*4] |-> !hot_spare_boot_advance_o;
  endproperty
  a_spare_off: assert property (p_spare_off)
    else $error("hot spare advance while timer off");
  property p_spare_pulse;
    hot_spare_boot_advance_o |=> !hot_spare_boot_advance_o;
  endproperty
  a_spare_pulse: assert property (p_spare_pulse)
    else $error("hot spare advance longer than a cycle");
  property p_data_hold;
    age_q > 6'h28 && io_addr_i == SCAN_DATA_PORT_ADDR &&
      $past(io_addr_i) == SCAN_DATA_PORT_ADDR |-> $stable(io_rdata_o);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data port moved without a shift");
  property p_ovf;
    fifo_overflow_o |=> fifo_overflow_o;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag dropped");
endmodule : scr_reader_monitor
bind scr_reader scr_reader_monitor i_mon (.clk_i, .resetn_i, .io_addr_i,
  .io_wr_i, .io_wdata_i, .io_rdata_o, .ecc_correctable_i, .fan1_error_i,
  .fan2_error_i, .temp1_caution_i, .temp2_caution_i, .irq13_o,
  .hot_spare_boot_advance_o, .fifo_overflow_o);
`default_nettype wire

// ===== testbench/scr_reader_tb_top.sv
/*
  Self-checking bench for the chain reader.
  Assumes the board model on the status pins.
*/
`timescale 1ns/1ns
`default_nettype none
module scr_reader_tb_top
  import scr_pkg::*;
;
  localparam logic [7:0] ID = 8'h5a; // Arbitrary value
  localparam logic [7:0] REV = 8'h13;
  localparam logic [7:0] INFO1 = {4'ha, 2'h1, 1'b1, 1'b0};
  localparam logic [7:0] INFO2 = {INFO2_RESERVED, 3'h2};
  logic clk = 1'b0;
  logic sclk = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic spare_start = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] ctl = CONTROL_RESET;
  logic [7:0] pulses = 8'h00;
  logic [7:0] got;
  logic [4:0] ev = 5'h00;
  wire logic [7:0] rdat, bid, brev;
  wire logic [3:0] bsw;
  wire logic [1:0] bris;
  wire logic bfan, btmp, cpu1, cpu2, irq, adv, ovf;
  int error_cnt = 0;
  int n_compared = 0;
  // Clocks, the link one offset from the system one
  always #5 clk = ~clk;
  initial begin
    #1;
    forever #3 sclk = ~sclk;
  end
  // Count hot spare advance pulses
  always @(posedge clk) if (adv === 1'b1) pulses <= pulses + 8'h01;
  scr_board_model i_board (.id_o(bid), .rev_o(brev), .sw_o(bsw),
    .riser_o(bris), .fan_o(bfan), .temp_o(btmp), .cpu1_o(cpu1),
    .cpu2_o(cpu2));
  scr_reader #(.SPARE_CYCLES(20)) i_dut (.clk_i(clk), .resetn_i(resetn),
    .shift_clk_i(sclk), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
    .io_wdata_i(wdat), .io_rdata_o(rdat), .board_identity_i(bid),
    .automatic_revision_value_i(brev), .config_switch_bank_i(bsw),
    .riser_type_i(bris), .fan_failure_i(bfan), .temp_caution_i(btmp),
    .first_cpu_internal_error_i(cpu1),
    .second_cpu_internal_error_i(cpu2), .ecc_correctable_i(ev[0]),
    .fan2_error_i(ev[1]), .fan1_error_i(ev[2]),
    .temp2_caution_i(ev[3]), .temp1_caution_i(ev[4]),
    .hot_spare_boot_start_i(spare_start), .irq13_o(irq),
    .hot_spare_boot_advance_o(adv), .fifo_overflow_o(ovf));
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic wr_io(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_io
  task automatic rd_io(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    d = rdat;
    @(negedge clk);
    rd = 1'b0;
  endtask : rd_io
  task automatic set_ctl(input logic [7:0] v);
    ctl = v;
    wr_io(SCAN_CONTROL_PORT_ADDR, v);
  endtask : set_ctl
  task automatic load();
    set_ctl(ctl & 8'hbf);
    set_ctl(ctl | 8'h40);
  endtask : load
  task automatic shift(output logic [7:0] d);
    set_ctl(ctl & 8'h7f);
    set_ctl(ctl | 8'h80);
    repeat (40) @(negedge clk);
    rd_io(SCAN_DATA_PORT_ADDR, d);
  endtask : shift
  task automatic t_reset();
    rd_io(SCAN_CONTROL_PORT_ADDR, got);
    chk(CONTROL_RESET, got);
    rd_io(SCAN_DATA_PORT_ADDR, got);
    chk(DATA_RESET, got);
    rd_io(8'h7a, got);
    chk(8'h00, got);
  endtask : t_reset
  task automatic t_chain();
    logic [7:0] exp [5];
    exp = '{ID, REV, INFO1, INFO2, FILLER_BYTE};
    load();
    for (int i = 0; i < 5; i++) begin
      shift(got);
      chk(exp[i], got);
    end
    wr_io(SCAN_DATA_PORT_ADDR, 8'h3c);
    rd_io(SCAN_DATA_PORT_ADDR, got);
    chk(FILLER_BYTE, got);
    load();
    shift(got);
    chk(ID, got);
  endtask : t_chain
  task automatic t_burst();
    load();
    set_ctl(ctl & 8'h7f);
    set_ctl(ctl | 8'h80);
    set_ctl(ctl & 8'h7f);
    set_ctl(ctl | 8'h80);
    repeat (40) @(negedge clk);
    rd_io(SCAN_DATA_PORT_ADDR, got);
    chk(ID, got);
    shift(got);
    chk(REV, got);
  endtask : t_burst
  task automatic t_irq();
    logic [7:0] en [5];
    en = '{8'h10, 8'h08, 8'h04, 8'h01, 8'h02};
    for (int i = 0; i < 5; i++) begin
      set_ctl(8'hc3);
      ev = 5'h01 << i;
      repeat (8) @(negedge clk);
      chk(8'h00, {7'h00, irq});
      set_ctl(8'hc0 | en[i]);
      repeat (8) @(negedge clk);
      chk(8'h01, {7'h00, irq});
    end
    ev = 5'h00;
    set_ctl(8'hc3);
  endtask : t_irq
  task automatic t_spare();
    spare_start = 1'b1;
    repeat (40) @(negedge clk);
    chk(8'h00, pulses);
    set_ctl(8'he3);
    repeat (40) @(negedge clk);
    chk(8'h01, {7'h00, pulses != 8'h00});
    spare_start = 1'b0;
    set_ctl(8'hc3);
    chk(8'h00, {7'h00, ovf});
  endtask : t_spare
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // Main sequence after eight reset cycles
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_chain();
    t_burst();
    t_irq();
    t_spare();
    wrap_up();
  end
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
endmodule : scr_reader_tb_top
`default_nettype wire

// ===== verilog/scr_fifo.sv
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module scr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Write side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Read side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  // Handshake and pointer update
  always_comb begin
    in_ready_o = (wp_q - rp_q) != (AW+1)'(DEPTH);
    out_valid_o = wp_q != rp_q;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  assign out_data_o = mem[rp_q[AW-1:0]];

  // Storage and pointers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule : scr_fifo
`default_nettype wire

// ===== verilog/scr_pkg.sv
/*
  Package for the board status chain reader: port offsets, control bit
  positions, chain layout and timing counts.
  Assumes a 100 MHz system clock and a 20 MHz shift clock domain.
*/
package scr_pkg;
  // Port offsets on the 8-bit I/O space
  localparam logic [7:0] SCAN_CONTROL_PORT_ADDR = 8'h78;
  localparam logic [7:0] SCAN_DATA_PORT_ADDR = 8'h79;
  // Control bit positions
  localparam int CTL_SHIFT_CLK_BIT = 7;
  localparam int CTL_LOAD_BIT = 6;
  localparam int CTL_HOT_SPARE_BOOT_BIT = 5;
  localparam int CTL_ECC_IRQ_BIT = 4;
  localparam int CTL_FAN2_BIT = 3;
  localparam int CTL_FAN1_BIT = 2;
  localparam int CTL_TEMP2_BIT = 1;
  localparam int CTL_TEMP1_BIT = 0;
  // Reset values, and the filler byte read past the end of the chain
  localparam logic [7:0] CONTROL_RESET = 8'hc3;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] FILLER_BYTE = 8'hff;
  // Chain layout
  localparam int CHAIN_BYTES = 4;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [4:0] INFO2_RESERVED = 5'h00;
  // Timing: shift clock rate and hot spare boot timeout
  localparam int SYS_CLK_MHZ = 100;
  localparam int SHIFT_CLK_MHZ = 20;
  localparam int SHIFT_DIV = SYS_CLK_MHZ / SHIFT_CLK_MHZ;
  localparam int SPARE_TIMEOUT_MS = 1;
  localparam int SPARE_TIMEOUT_CYC = SPARE_TIMEOUT_MS * SYS_CLK_MHZ * 1000;
endpackage : scr_pkg

// ===== verilog/scr_reader.sv
/*
  Board status chain reader: control port at 78h, data port at 79h.
  Software writes control bits to load the chain and to shift bytes;
  the data port shows the last shifted byte. Also holds enables for
  the hot spare boot timer, ECC reporting, fans and temperature.
  Assumes a simple 8-bit I/O strobe bus on clk_i, status pins from the
  board that are asynchronous, and a 20 MHz shift clock of its own.
*/
`timescale 1ns/1ns
`default_nettype none
module scr_reader
  import scr_pkg::*;
#(
  parameter int SPARE_CYCLES = SPARE_TIMEOUT_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link shift clock
  input wire logic shift_clk_i,
  // I/O port access
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Board status sources
  input wire logic [7:0] board_identity_i,
  input wire logic [7:0] automatic_revision_value_i,
  input wire logic [3:0] config_switch_bank_i,
  input wire logic [1:0] riser_type_i,
  input wire logic fan_failure_i,
  input wire logic temp_caution_i,
  input wire logic first_cpu_internal_error_i,
  input wire logic second_cpu_internal_error_i,
  // Management event sources
  input wire logic ecc_correctable_i,
  input wire logic fan1_error_i,
  input wire logic fan2_error_i,
  input wire logic temp1_caution_i,
  input wire logic temp2_caution_i,
  input wire logic hot_spare_boot_start_i,
  // Outputs
  output logic irq13_o,
  output logic hot_spare_boot_advance_o,
  output logic fifo_overflow_o
);
  // One synchroniser step for a bus of pins: returns the low 16 bits of s
  function automatic logic [15:0] sync_step(input logic [31:0] s,
                                            input logic [15:0] pin);
    sync_step = s[15:0];
  endfunction : sync_step

  logic [7:0] ctl_q, ctl_d;
  logic [7:0] data_q, data_d;
  logic load_tgl_q, load_tgl_d, burst_tgl_q, burst_tgl_d;
  logic [1:0] done_sync_q;
  logic done_seen_q, done_seen_d;
  logic [31:0] spare_cnt_q, spare_cnt_d;
  logic spare_adv_q, spare_adv_d;
  logic [31:0] snap_q, snap_d;
  logic irq_q, irq_d;
  logic ovf_q, ovf_d;
  logic [15:0] ev_s1_q, ev_s2_q;
  logic [31:0] st_s1_q, st_s2_q;
  logic link_resetn_q1, link_resetn_q2;
  logic done_tgl;
  logic [7:0] link_byte;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic ctl_wr, data_rd;
  logic [31:0] chain_img;

  assign ctl_wr = io_wr_i && (io_addr_i == SCAN_CONTROL_PORT_ADDR);
  assign data_rd = io_rd_i && (io_addr_i == SCAN_DATA_PORT_ADDR);

  // Chain image in fixed byte order, first byte in the top bits
  assign chain_img = {st_s2_q[7:0],
                      st_s2_q[15:8],
                      st_s2_q[19:16], st_s2_q[21:20],
                      st_s2_q[23], st_s2_q[22],
                      INFO2_RESERVED, 1'b0,
                      st_s2_q[24], st_s2_q[25]};

  // Control port writes: low-high edges of load and clock bits
  always_comb begin
    ctl_d = ctl_q;
    load_tgl_d = load_tgl_q;
    burst_tgl_d = burst_tgl_q;
    snap_d = snap_q;
    if (ctl_wr) begin
      ctl_d = io_wdata_i;
      if (!ctl_q[CTL_LOAD_BIT] && io_wdata_i[CTL_LOAD_BIT]) begin
        // Snapshot stays still while the toggle crosses to the link side
        snap_d = chain_img;
        load_tgl_d = ~load_tgl_q;
      end
      if (!ctl_q[CTL_SHIFT_CLK_BIT] && io_wdata_i[CTL_SHIFT_CLK_BIT]) begin
        burst_tgl_d = ~burst_tgl_q;
      end
    end
  end

  // Bytes from the shift domain enter the FIFO, then the data port
  always_comb begin
    done_seen_d = done_sync_q[1];
    fifo_in_valid = done_sync_q[1] != done_seen_q;
    ovf_d = ovf_q | (fifo_in_valid && !fifo_in_ready);
    data_d = data_q;
    if (fifo_out_valid) begin
      data_d = fifo_out_data;
    end
  end

  // Hot spare boot timer and shared interrupt
  always_comb begin
    spare_cnt_d = spare_cnt_q;
    spare_adv_d = 1'b0;
    if (!ctl_q[CTL_HOT_SPARE_BOOT_BIT] || !ev_s2_q[5]) begin
      spare_cnt_d = '0;
    end else if (spare_cnt_q == 32'(SPARE_CYCLES - 1)) begin
      spare_cnt_d = '0;
      spare_adv_d = 1'b1;
    end else begin
      spare_cnt_d = spare_cnt_q + 32'h1;
    end
    irq_d = (ctl_q[CTL_ECC_IRQ_BIT] && ev_s2_q[0])
          | (ctl_q[CTL_FAN1_BIT] && ev_s2_q[1])
          | (ctl_q[CTL_FAN2_BIT] && ev_s2_q[2])
          | (!ctl_q[CTL_TEMP1_BIT] && ev_s2_q[3])
          | (!ctl_q[CTL_TEMP2_BIT] && ev_s2_q[4]);
  end

  // Read data mux; data port is read-only
  always_comb begin
    io_rdata_o = 8'h00;
    if (io_addr_i == SCAN_CONTROL_PORT_ADDR) begin
      io_rdata_o = ctl_q;
    end else if (io_addr_i == SCAN_DATA_PORT_ADDR) begin
      io_rdata_o = data_q;
    end
  end

  assign irq13_o = irq_q;
  assign hot_spare_boot_advance_o = spare_adv_q;
  assign fifo_overflow_o = ovf_q;

  // System domain registers and pin synchronisers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctl_q <= CONTROL_RESET;
      data_q <= DATA_RESET;
      load_tgl_q <= 1'b0;
      burst_tgl_q <= 1'b0;
      done_sync_q <= '0;
      done_seen_q <= 1'b0;
      spare_cnt_q <= '0;
      spare_adv_q <= 1'b0;
      snap_q <= '0;
      irq_q <= 1'b0;
      ovf_q <= 1'b0;
      ev_s1_q <= '0;
      ev_s2_q <= '0;
      st_s1_q <= '0;
      st_s2_q <= '0;
    end else begin
      ctl_q <= ctl_d;
      data_q <= data_d;
      load_tgl_q <= load_tgl_d;
      burst_tgl_q <= burst_tgl_d;
      done_sync_q <= {done_sync_q[0], done_tgl};
      done_seen_q <= done_seen_d;
      spare_cnt_q <= spare_cnt_d;
      spare_adv_q <= spare_adv_d;
      snap_q <= snap_d;
      irq_q <= irq_d;
      ovf_q <= ovf_d;
      ev_s1_q <= {10'h000, hot_spare_boot_start_i, temp2_caution_i,
                  temp1_caution_i, fan2_error_i, fan1_error_i,
                  ecc_correctable_i};
      ev_s2_q <= sync_step({16'h0000, ev_s1_q}, 16'h0000);
      st_s1_q <= {6'h00, first_cpu_internal_error_i,
                  second_cpu_internal_error_i, fan_failure_i,
                  temp_caution_i, riser_type_i, config_switch_bank_i,
                  automatic_revision_value_i, board_identity_i};
      st_s2_q <= st_s1_q;
    end
  end

  // Reset released into the shift domain through two flops
  always_ff @(posedge shift_clk_i) begin
    link_resetn_q1 <= resetn_i;
    link_resetn_q2 <= link_resetn_q1;
  end

  // Link-side shift engine
  scr_shifter #(
    .NBYTES(CHAIN_BYTES)
  ) u_shifter (
    .shift_clk_i(shift_clk_i),
    .resetn_i(link_resetn_q2),
    .load_tgl_i(load_tgl_q),
    .burst_tgl_i(burst_tgl_q),
    .chain_i(snap_q),
    .done_tgl_o(done_tgl),
    .byte_o(link_byte)
  );

  // Byte buffer between shift engine and data port
  scr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(link_byte),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(1'b1),
    .out_data_o(fifo_out_data)
  );
endmodule : scr_reader
`default_nettype wire

// ===== verilog/scr_shifter.sv
/*
  Link-side shift logic on the 20 MHz shift clock: captures the chain
  into a shift register on load and shifts out bytes, eight clocks each.
  Assumes load and burst requests arrive as toggles from the system
  domain and that the reset is already synchronised to this clock.
*/
`timescale 1ns/1ns
`default_nettype none
module scr_shifter
  import scr_pkg::*;
#(
  parameter int NBYTES = CHAIN_BYTES
) (
  // Link clock and reset
  input wire logic shift_clk_i,
  input wire logic resetn_i,
  // Requests from system domain, as toggles
  input wire logic load_tgl_i,
  input wire logic burst_tgl_i,
  // Parallel chain image
  input wire logic [NBYTES*8-1:0] chain_i,
  // Byte done, as toggle, with data
  output logic done_tgl_o,
  output logic [7:0] byte_o
);
  logic [1:0] ld_sync_q, bu_sync_q;
  logic ld_seen_q, ld_seen_d, bu_seen_q, bu_seen_d;
  logic [NBYTES*8-1:0] sr_q, sr_d;
  logic [7:0] byte_q, byte_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] left_q, left_d;
  logic done_q, done_d;

  // Load capture, burst counting and shift
  always_comb begin
    ld_seen_d = ld_sync_q[1];
    bu_seen_d = bu_sync_q[1];
    sr_d = sr_q;
    byte_d = byte_q;
    bits_d = bits_q;
    left_d = left_q;
    done_d = done_q;
    if (ld_sync_q[1] != ld_seen_q) begin
      sr_d = chain_i;
      left_d = 8'(NBYTES*8);
      bits_d = '0;
    end else if (bits_q != 4'h0) begin
      byte_d = {byte_q[6:0], left_q != 8'h0 ? sr_q[NBYTES*8-1] : 1'b1};
      if (left_q != 8'h0) begin
        sr_d = {sr_q[NBYTES*8-2:0], 1'b0};
        left_d = left_q - 8'h1;
      end
      bits_d = bits_q - 4'h1;
      if (bits_q == 4'h1) begin
        done_d = ~done_q;
      end
    end else if (bu_sync_q[1] != bu_seen_q) begin
      bits_d = 4'(BITS_PER_BYTE);
    end
    if (bits_q != 4'h0) begin
      bu_seen_d = bu_seen_q;
      if (bu_sync_q[1] != bu_seen_q) begin
        bu_seen_d = bu_sync_q[1];
      end
    end
  end

  assign done_tgl_o = done_q;
  assign byte_o = byte_q;

  // Registers and request synchronisers
  always_ff @(posedge shift_clk_i) begin
    if (!resetn_i) begin
      ld_sync_q <= '0;
      bu_sync_q <= '0;
      ld_seen_q <= 1'b0;
      bu_seen_q <= 1'b0;
      sr_q <= '0;
      byte_q <= DATA_RESET;
      bits_q <= '0;
      left_q <= '0;
      done_q <= 1'b0;
    end else begin
      ld_sync_q <= {ld_sync_q[0], load_tgl_i};
      bu_sync_q <= {bu_sync_q[0], burst_tgl_i};
      ld_seen_q <= ld_seen_d;
      bu_seen_q <= bu_seen_d;
      sr_q <= sr_d;
      byte_q <= byte_d;
      bits_q <= bits_d;
      left_q <= left_d;
      done_q <= done_d;
    end
  end
endmodule : scr_shifter
`default_nettype wire
